// ==== bie_consts.vh ====
// constants for the branch and increment execution unit
// assumes inclusion by bie_branch_increment_exec.v only
`ifndef BIE_CONSTS_VH
`define BIE_CONSTS_VH

// full opcodes
`define BIE_OP_DECREMENT_BRANCH_NONZERO_DIR  8'hD5
`define BIE_OP_INC_ACC   8'h04
`define BIE_OP_INC_DIR   8'h05
`define BIE_OP_INC_DATA_POINTER_PAIR  8'hA3
`define BIE_OP_JB        8'h20
`define BIE_OP_JBC       8'h10
`define BIE_OP_JNB       8'h30
`define BIE_OP_JC        8'h40
`define BIE_OP_JNC       8'h50
`define BIE_OP_JZ        8'h60
`define BIE_OP_JNZ       8'h70
`define BIE_OP_JMP_IND   8'h73

// opcode prefixes for register-field forms
`define BIE_OP_DECREMENT_BRANCH_NONZERO_RN_HI 5'h1B
`define BIE_OP_INC_RN_HI  5'h01
`define BIE_OP_INC_IND_HI 7'h03

// instruction lengths in bytes
`define BIE_LEN_1        2'h1
`define BIE_LEN_2        2'h2
`define BIE_LEN_3        2'h3

// reset and arithmetic constants
`define BIE_PC_RESET     16'h0000
`define BIE_BYTE_ZERO    8'h00
`define BIE_BYTE_ONE     8'h01
`define BIE_WORD_ONE     16'h0001
`define BIE_HI_ZERO      8'h00

// address and sign fill fields
`define BIE_BANK_PAD     3'h0
`define BIE_PTR_PAD      2'h0
`define BIE_SIGN_FILL    8

`endif

// ==== bie_branch_increment_exec.v ====
// execution unit for loop, increment and conditional jump instructions
// assumes program and data memory reads are combinational in the same
// cycle, carry, accumulator and pointer live in the core's own registers
`timescale 1ns/100ps
`default_nettype none
`include "bie_consts.vh"

module bie_branch_increment_exec (
   // clock and reset
   input  wire        mclk,
   input  wire        rst_b,
   // program memory
   output wire [15:0] pmAddr,
   output wire        pmRead,
   input  wire [7:0]  pmData,
   // internal data memory and special registers
   output reg  [7:0]  dmRdAddr,
   output wire        dmRead,
   output wire        dmLatchRead,
   input  wire [7:0]  dmRdData,
   output reg  [7:0]  dmWrAddr,
   output reg  [7:0]  dmWrData,
   output reg         dmWe,
   // bit space
   output wire [7:0]  bitAddr,
   output wire        bitRead,
   input  wire        bitRdData,
   output reg         bitClr,
   // core state
   input  wire [1:0]  bankSel,
   input  wire        carryFlag,
   input  wire [7:0]  accIn,
   input  wire [15:0] dptrIn,
   output reg         accWe,
   output reg  [7:0]  accWrData,
   output reg         dptrWe,
   output reg  [15:0] dptrWrData,
   // status
   output wire [15:0] pcOut,
   output reg         instrDone,
   output reg         illegalOp
);

   // sequencer states
   localparam S_FETCH = 3'b000;
   localparam S_OPA   = 3'b001;
   localparam S_OPB   = 3'b010;
   localparam S_IND   = 3'b011;
   localparam S_EXEC  = 3'b100;

   // architectural and holding registers
   reg  [2:0]  state_reg;
   reg  [15:0] pc_reg;
   reg  [7:0]  opcode_reg;
   reg  [7:0]  op1_reg;
   reg  [7:0]  op2_reg;
   reg  [7:0]  ptr_reg;
   reg  [2:0]  state_next;
   reg  [15:0] pc_next;

   // decode and datapath nets
   wire [7:0]  curOp;
   wire        isDjnzR;
   wire        isDjnzD;
   wire        isIncA;
   wire        isIncR;
   wire        isIncD;
   wire        isIncI;
   wire        isIncDp;
   wire        isJb;
   wire        isJbc;
   wire        isJnb;
   wire        isJc;
   wire        isJnc;
   wire        isJz;
   wire        isJnz;
   wire        isJmpI;
   wire        known;
   reg  [1:0]  instrLen;
   wire [7:0]  relByte;
   wire [15:0] relExt;
   wire [15:0] target;
   wire [7:0]  decVal;
   wire [7:0]  incVal;
   wire        accZero;
   reg         takeBranch;

   // decode looks at the fetched byte in fetch, the held opcode later
   assign curOp   = (state_reg == S_FETCH) ? pmData : opcode_reg;
   assign isDjnzR = (curOp[7:3] == `BIE_OP_DECREMENT_BRANCH_NONZERO_RN_HI);
   assign isDjnzD = (curOp == `BIE_OP_DECREMENT_BRANCH_NONZERO_DIR);
   assign isIncA  = (curOp == `BIE_OP_INC_ACC);
   assign isIncR  = (curOp[7:3] == `BIE_OP_INC_RN_HI);
   assign isIncD  = (curOp == `BIE_OP_INC_DIR);
   assign isIncI  = (curOp[7:1] == `BIE_OP_INC_IND_HI);
   assign isIncDp = (curOp == `BIE_OP_INC_DATA_POINTER_PAIR);
   assign isJb    = (curOp == `BIE_OP_JB);
   assign isJbc   = (curOp == `BIE_OP_JBC);
   assign isJc    = (curOp == `BIE_OP_JC);
   assign isJnc   = (curOp == `BIE_OP_JNC);
   assign isJmpI  = (curOp == `BIE_OP_JMP_IND);
   assign isJnb   = (curOp == `BIE_OP_JNB);
   assign isJnz   = (curOp == `BIE_OP_JNZ);
   assign isJz    = (curOp == `BIE_OP_JZ);

   // anything outside this group is flagged and skipped
   assign known = isDjnzR | isDjnzD | isIncA | isIncR | isIncD | isIncI |
                  isIncDp | isJb | isJbc | isJnb | isJc | isJnc | isJz |
                  isJnz | isJmpI;

   // byte count per opcode
   always @* begin
      if (isDjnzD | isJb | isJbc | isJnb) begin
         instrLen = `BIE_LEN_3;
      end else if (isDjnzR | isIncD | isJc | isJnc | isJz | isJnz) begin
         instrLen = `BIE_LEN_2;
      end else begin
         instrLen = `BIE_LEN_1;
      end
   end

   // offset sits in the last byte; pc already points past the instruction
   assign relByte = (isDjnzD | isJb | isJbc | isJnb) ? op2_reg
                                                     : op1_reg;
   assign relExt  = {{`BIE_SIGN_FILL{relByte[7]}}, relByte};
   assign target  = pc_reg + relExt;

   assign decVal  = dmRdData - `BIE_BYTE_ONE;
   assign incVal  = dmRdData + `BIE_BYTE_ONE;
   // condition shared by both accumulator jumps
   assign accZero = (accIn == `BIE_BYTE_ZERO);

   // program fetch runs from the held pc
   assign pmAddr = pc_reg;
   assign pmRead = (state_reg == S_FETCH) | (state_reg == S_OPA) |
                   (state_reg == S_OPB);
   assign pcOut  = pc_reg;

   // data memory read address: bank register, direct byte or pointer
   always @* begin
      dmRdAddr = `BIE_BYTE_ZERO;
      if (state_reg == S_IND) begin
         dmRdAddr = {`BIE_BANK_PAD, bankSel, `BIE_PTR_PAD, opcode_reg[0]};
      end else if (isDjnzR | isIncR) begin
         dmRdAddr = {`BIE_BANK_PAD, bankSel, opcode_reg[2:0]};
      end else if (isDjnzD | isIncD) begin
         dmRdAddr = op1_reg;
      end else if (isIncI) begin
         dmRdAddr = ptr_reg;
      end
   end

   // data reads only in the pointer and exec cycles
   assign dmRead = (state_reg == S_IND) |
                   ((state_reg == S_EXEC) &
                    (isDjnzR | isDjnzD | isIncR | isIncD | isIncI));
   // ports modified here must read back the latch, not the pins
   assign dmLatchRead = (state_reg == S_EXEC) &
                        (isDjnzD | isIncD | isIncI | isJbc);

   // bit jumps keep their address in the first operand byte
   assign bitAddr = op1_reg;
   assign bitRead = (state_reg == S_EXEC) & (isJb | isJbc | isJnb);

   // branch condition per opcode
   always @* begin
      takeBranch = 1'b0;
      if (isDjnzR | isDjnzD) begin
         takeBranch = (decVal != `BIE_BYTE_ZERO);
      end else if (isJb | isJbc) begin
         takeBranch = bitRdData;
      end else if (isJnb) begin
         takeBranch = ~bitRdData;
      end else if (isJc) begin
         takeBranch = carryFlag;
      end else if (isJnc) begin
         takeBranch = ~carryFlag;
      end else if (isJz) begin
         takeBranch = accZero;
      end else if (isJnz) begin
         takeBranch = ~accZero;
      end
   end

   // next program counter; every fetched byte steps it, exec may redirect
   always @* begin
      pc_next = pc_reg;
      case (state_reg)
         S_FETCH, S_OPA, S_OPB: begin
            pc_next = pc_reg + `BIE_WORD_ONE;
         end
         S_EXEC: begin
            if (isJmpI) begin
               // unsigned accumulator, carry runs into the high byte
               pc_next = dptrIn + {`BIE_HI_ZERO, accIn};
            end else if (takeBranch) begin
               pc_next = target;
            end
         end
         default: begin
            pc_next = pc_reg;
         end
      endcase
   end

   // next sequencer state; operand bytes or the pointer read first, then one exec cycle
   always @* begin
      state_next = S_FETCH;
      case (state_reg)
         S_FETCH: begin
            if (!known) begin
               // foreign opcode is skipped as one byte
               state_next = S_FETCH;
            end else if (instrLen != `BIE_LEN_1) begin
               state_next = S_OPA;
            end else if (isIncI) begin
               state_next = S_IND;
            end else begin
               state_next = S_EXEC;
            end
         end
         S_OPA: begin
            if (instrLen == `BIE_LEN_3) begin
               state_next = S_OPB;
            end else begin
               state_next = S_EXEC;
            end
         end
         S_OPB: begin
            state_next = S_EXEC;
         end
         S_IND: begin
            state_next = S_EXEC;
         end
         S_EXEC: begin
            state_next = S_FETCH;
         end
         default: begin
            state_next = S_FETCH;
         end
      endcase
   end

   // sequencer; no flag output exists, so no path can alter flags
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg  <= S_FETCH;
         pc_reg     <= `BIE_PC_RESET;
         opcode_reg <= `BIE_BYTE_ZERO;
         op1_reg    <= `BIE_BYTE_ZERO;
         op2_reg    <= `BIE_BYTE_ZERO;
         ptr_reg    <= `BIE_BYTE_ZERO;
         dmWrAddr   <= `BIE_BYTE_ZERO;
         dmWrData   <= `BIE_BYTE_ZERO;
         dmWe       <= 1'b0;
         bitClr     <= 1'b0;
         accWe      <= 1'b0;
         accWrData  <= `BIE_BYTE_ZERO;
         dptrWe     <= 1'b0;
         dptrWrData <= `BIE_PC_RESET;
         instrDone  <= 1'b0;
         illegalOp  <= 1'b0;
      end else begin
         // write strobes and status are one-cycle pulses
         dmWe      <= 1'b0;
         bitClr    <= 1'b0;
         accWe     <= 1'b0;
         dptrWe    <= 1'b0;
         instrDone <= 1'b0;
         illegalOp <= 1'b0;
         state_reg <= state_next;
         pc_reg    <= pc_next;
         case (state_reg)
            S_FETCH: begin
               opcode_reg <= pmData;
               if (!known) begin
                  // flagged here, the next byte is fetched as an opcode
                  illegalOp <= 1'b1;
                  instrDone <= 1'b1;
               end
            end
            S_OPA: begin
               op1_reg <= pmData;
            end
            S_OPB: begin
               op2_reg <= pmData;
            end
            S_IND: begin
               // indirect pointer register gives the target byte address
               ptr_reg <= dmRdData;
            end
            S_EXEC: begin
               // every write and the done pulse leave together
               instrDone <= 1'b1;
               if (isDjnzR | isDjnzD) begin
                  dmWe     <= 1'b1;
                  dmWrAddr <= dmRdAddr;
                  dmWrData <= decVal;
               end
               if (isIncR | isIncD | isIncI) begin
                  dmWe     <= 1'b1;
                  dmWrAddr <= dmRdAddr;
                  dmWrData <= incVal;
               end
               if (isIncA) begin
                  accWe     <= 1'b1;
                  accWrData <= accIn + `BIE_BYTE_ONE;
               end
               if (isIncDp) begin
                  dptrWe     <= 1'b1;
                  dptrWrData <= dptrIn + `BIE_WORD_ONE;
               end
               if (isJbc & bitRdData) begin
                  bitClr <= 1'b1;
               end
            end
            default: begin
               // unused codes recover through the next-state logic
               instrDone <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== bie_exec_chk.sv ====
// port assertions for the branch and increment execution unit
// assumes bound into bie_branch_increment_exec, one clock domain
`timescale 1ns/100ps
`default_nettype none
module bie_exec_chk (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        dmRead,
   input wire logic        dmLatchRead,
   input wire logic        dmWe,
   input wire logic [7:0]  bitAddr,
   input wire logic        bitRead,
   input wire logic        bitRdData,
   input wire logic        bitClr,
   input wire logic [7:0]  accIn,
   input wire logic [15:0] dptrIn,
   input wire logic        accWe,
   input wire logic [7:0]  accWrData,
   input wire logic        dptrWe,
   input wire logic [15:0] dptrWrData,
   input wire logic        instrDone,
   input wire logic        illegalOp
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // side effects only ever land with the closing pulse
   illegal_done_a: assert property (illegalOp |-> instrDone) else $error("illegal without done");
   write_done_a: assert property (dmWe |-> instrDone) else $error("data write off done");
   acc_done_a: assert property (accWe |-> instrDone) else $error("acc write off done");
   acc_inc_a: assert property (accWe |-> accWrData == $past(accIn) + 8'h01)
      else $error("acc increment wrong");
   data_pointer_pair_inc_a: assert property (dptrWe |-> dptrWrData == $past(dptrIn) + 16'h0001)
      else $error("pointer increment wrong");
   clear_cause_a: assert property (bitClr |-> $past(bitRead) && $past(bitRdData))
      else $error("bit cleared without set bit");
   clear_addr_a: assert property (bitClr |-> $stable(bitAddr))
      else $error("clear address moved");
   latch_read_a: assert property (dmLatchRead |-> (dmRead ^ bitRead))
      else $error("latch read with no read");
   clear_done_a: assert property (bitClr |-> instrDone)
      else $error("bit clear off done");
endmodule
bind bie_branch_increment_exec bie_exec_chk u_chk (.mclk(mclk), .rst_b(rst_b),
   .dmRead(dmRead), .dmLatchRead(dmLatchRead), .dmWe(dmWe), .bitAddr(bitAddr),
   .bitRead(bitRead), .bitRdData(bitRdData), .bitClr(bitClr), .accIn(accIn),
   .dptrIn(dptrIn), .accWe(accWe), .accWrData(accWrData), .dptrWe(dptrWe),
   .dptrWrData(dptrWrData), .instrDone(instrDone), .illegalOp(illegalOp));
`default_nettype wire

// ==== bie_mem_model.sv ====
// program memory, data memory and bit space seen by the exec unit
// assumes combinational reads and writes on the rising edge
`timescale 1ns/100ps
`default_nettype none
module bie_mem_model (
   input  wire logic        mclk,
   input  wire logic [15:0] pmAddr,
   input  wire logic        pmRead,
   output logic      [7:0]  pmData,
   input  wire logic [7:0]  dmRdAddr,
   input  wire logic        dmRead,
   input  wire logic        dmLatchRead,
   output logic      [7:0]  dmRdData,
   input  wire logic [7:0]  dmWrAddr,
   input  wire logic [7:0]  dmWrData,
   input  wire logic        dmWe,
   input  wire logic [7:0]  bitAddr,
   input  wire logic        bitRead,
   output logic             bitRdData,
   input  wire logic        bitClr
);
   logic [7:0] pm [0:65535];
   logic [7:0] dm [0:255];
   logic       bits [0:255];
   logic [7:0] junkReg = 8'h5A;
   // idle read lines show a moving pattern, never the last value
   always @(posedge mclk) begin
      junkReg <= junkReg + 8'h3B;
      if (dmWe) dm[dmWrAddr] <= dmWrData;
      if (bitClr) bits[bitAddr] <= 1'b0;
   end
   assign pmData = pmRead ? pm[pmAddr] : junkReg;
   // port pins read back as the inverted latch so a pin read is caught
   assign dmRdData = !dmRead ? junkReg : (dmRdAddr[7] && !dmLatchRead) ? ~dm[dmRdAddr]
                     : dm[dmRdAddr];
   assign bitRdData = bitRead ? bits[bitAddr] : junkReg[0];
endmodule
`default_nettype wire

// ==== bie_branch_increment_exec_tb_top.sv ====
// random instruction stream bench for the exec unit
// assumes bie_mem_model answers all program and data reads
`timescale 1ns/100ps
`default_nettype none
module bie_branch_increment_exec_tb_top;
   logic        mclk = 1'b0, rst_b = 1'b0, carryFlag = 1'b0, take;
   logic [1:0]  bankSel = 2'h0;
   logic [7:0]  accIn = 8'h00, op, b1, v, r, a, o;
   logic [15:0] dptrIn = 16'h0000, pc = 16'h0000;
   wire  [15:0] pmAddr, pcOut, dptrWrData;
   wire  [7:0]  pmData, dmRdAddr, dmRdData, dmWrAddr, dmWrData, bitAddr, accWrData;
   wire         pmRead, dmRead, dmLatchRead, dmWe, bitRead, bitRdData, bitClr;
   wire         accWe, dptrWe, instrDone, illegalOp;
   integer      seed = 88, bad_count = 0, n_checks = 0, cycleCount = 0, i;
   bie_branch_increment_exec u_dut (.mclk(mclk), .rst_b(rst_b), .pmAddr(pmAddr),
      .pmRead(pmRead), .pmData(pmData), .dmRdAddr(dmRdAddr), .dmRead(dmRead),
      .dmLatchRead(dmLatchRead), .dmRdData(dmRdData), .dmWrAddr(dmWrAddr),
      .dmWrData(dmWrData), .dmWe(dmWe), .bitAddr(bitAddr), .bitRead(bitRead),
      .bitRdData(bitRdData), .bitClr(bitClr), .bankSel(bankSel), .carryFlag(carryFlag),
      .accIn(accIn), .dptrIn(dptrIn), .accWe(accWe), .accWrData(accWrData),
      .dptrWe(dptrWe), .dptrWrData(dptrWrData), .pcOut(pcOut), .instrDone(instrDone),
      .illegalOp(illegalOp));
   bie_mem_model u_mem (.mclk(mclk), .pmAddr(pmAddr), .pmRead(pmRead), .pmData(pmData),
      .dmRdAddr(dmRdAddr), .dmRead(dmRead), .dmLatchRead(dmLatchRead),
      .dmRdData(dmRdData), .dmWrAddr(dmWrAddr), .dmWrData(dmWrData), .dmWe(dmWe),
      .bitAddr(bitAddr), .bitRead(bitRead), .bitRdData(bitRdData), .bitClr(bitClr));
   always #2.5 mclk = ~mclk;
   // hang guard, far above the 200 short instructions run here
   always @(posedge mclk) begin
      cycleCount = cycleCount + 1;
      if (cycleCount == 5000) begin
         bad_count = bad_count + 1;
         end_sim;
      end
   end
   task end_sim;
      if (bad_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // branch target: next instruction plus sign-extended offset
   function automatic logic [15:0] tgt(input logic [15:0] p, input logic [1:0] n,
                                        input logic [7:0] ofs, input logic tk);
      tgt = p + {14'h0000, n} + (tk ? {{8{ofs[7]}}, ofs} : 16'h0000);
   endfunction
   // bytes go in before the fetch edge; results read in the done cycle
   task run(input logic [7:0] c, input logic [7:0] x, input logic [7:0] y,
            input logic [15:0] e);
      u_mem.pm[pc] = c;
      u_mem.pm[pc + 16'h0001] = x;
      u_mem.pm[pc + 16'h0002] = y;
      repeat (12) begin
         @(negedge mclk);
         if (instrDone === 1'b1) break;
      end
      chk(instrDone, 1'b1);
      chk(pcOut, e);
      pc = e;
   endtask
   initial begin
      repeat (6) @(negedge mclk);
      rst_b = 1'b1;
      for (i = 0; i < 200; i = i + 1) begin
         if (i == 100) begin
            // mid-run reset: pc and pulses drop at once
            rst_b = 1'b0;
            @(negedge mclk);
            chk(pcOut, 16'h0000);
            chk(instrDone, 1'b0);
            rst_b = 1'b1;
            pc = 16'h0000;
         end
         {op, b1, v, r} = $random(seed);
         if (i < 27) v = (i / 9 == 0) ? 8'h00 : (i / 9 == 1) ? 8'h01 : 8'hFF;
         bankSel = r[1:0];
         carryFlag = r[2];
         accIn = v;
         a = {3'b000, bankSel, op[2:0]};
         case (i % 9)
            0: begin
               u_mem.dm[a] = v;
               run({5'h1B, op[2:0]}, b1, 8'h00, tgt(pc, 2'h2, b1, v != 8'h01));
               chk(dmWrData, 8'(v - 8'h01));
               chk(dmWrAddr, a);
            end
            1: begin
               u_mem.dm[b1] = v;
               run(8'hD5, b1, op, tgt(pc, 2'h3, op, v != 8'h01));
               chk(dmWrData, 8'(v - 8'h01));
               chk(dmWe, 1'b1);
            end
            2: begin
               b1[7] = 1'b1;
               a = {3'b000, bankSel, 2'b00, op[0]};
               u_mem.dm[a] = b1;
               u_mem.dm[b1] = v;
               if (op[2]) u_mem.dm[{3'b000, bankSel, op[5:3]}] = v;
               if (op[2]) run({5'h01, op[5:3]}, 8'h00, 8'h00, pc + 16'h0001);
               else if (op[1]) run({7'h03, op[0]}, 8'h00, 8'h00, pc + 16'h0001);
               else run(8'h05, b1, 8'h00, pc + 16'h0002);
               chk(dmWrData, 8'(v + 8'h01));
               chk(dmWrAddr, op[2] ? {3'b000, bankSel, op[5:3]} : b1);
            end
            3: begin
               run(8'h04, 8'h00, 8'h00, pc + 16'h0001);
               chk(accWe, 1'b1);
               chk(accWrData, 8'(v + 8'h01));
            end
            4: begin
               dptrIn = {v, (i < 27) ? 8'hFF : b1};
               run(8'hA3, 8'h00, 8'h00, pc + 16'h0001);
               chk(dptrWrData, dptrIn + 16'h0001);
            end
            5: begin
               u_mem.bits[b1] = v[0];
               o = (r[4:3] == 2'h1) ? 8'h10 : r[4] ? 8'h30 : 8'h20;
               take = (o == 8'h30) ? !v[0] : v[0];
               run(o, b1, op, tgt(pc, 2'h3, op, take));
               chk(bitClr, o == 8'h10 && v[0]);
            end
            6: begin
               o = 8'h40 + {2'b00, r[4:3], 4'h0};
               take = {accIn != 8'h00, accIn == 8'h00, !carryFlag, carryFlag} >> r[4:3];
               run(o, op, 8'h00, tgt(pc, 2'h2, op, take));
               chk(accWe, 1'b0);
            end
            7: begin
               dptrIn = {b1, op};
               run(8'h73, 8'h00, 8'h00, {8'h00, v} + dptrIn);
               chk(dptrWe, 1'b0);
            end
            default: begin
               run(8'hA5, 8'h00, 8'h00, pc + 16'h0001);
               chk(illegalOp, 1'b1);
            end
         endcase
      end
      end_sim;
   end
endmodule
`default_nettype wire
